// ===== pkg/dmrb_params.svh
// Field positions, encodings and reset values of the mode register and burst logic
`ifndef DMRB_PARAMS_SVH
`define DMRB_PARAMS_SVH

`define DMRB_MR_W 13
`define DMRB_MR_RESET 13'h0000
`define DMRB_BL_LSB 0
`define DMRB_BL_MSB 2
`define DMRB_BT_BIT 3
`define DMRB_CL_LSB 4
`define DMRB_CL_MSB 6
`define DMRB_OPM_LSB 7
`define DMRB_OPM_MSB 12
`define DMRB_DLL_RST_BIT 8
`define DMRB_ROW_TOP_BIT 12

`define DMRB_BL2 3'h1
`define DMRB_BL4 3'h2
`define DMRB_BL8 3'h3

`define DMRB_CL2 3'h2
`define DMRB_CL25 3'h6
`define DMRB_CL3 3'h3

`define DMRB_OPM_NORMAL 6'h00
`define DMRB_OPM_DLL_RST 6'h02

`define DMRB_BA_MODE 2'h0

`define DMRB_OP_LMR 3'h0
`define DMRB_OP_READ 3'h5
`define DMRB_OP_WRITE 3'h4
`define DMRB_OP_BST 3'h6

`define DMRB_COL_LO_W 10
`define DMRB_COL_W 11
`define DMRB_COL_EXT_PIN 11

`define DMRB_RD_TAP_CL2 3'h2
`define DMRB_RD_TAP_CL3 3'h4
`define DMRB_RD_TAP_NONE 3'h0

`define DMRB_MASK_BL2 3'h1
`define DMRB_MASK_BL4 3'h3
`define DMRB_MASK_BL8 3'h7

`endif

// ===== pkg/dmrb_pkg.sv
// Types shared by the mode register and burst sequencing logic
package dmrb_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
  } dmrb_cmd_t;

  typedef struct packed {
    logic [5:0] op_mode;
    logic [2:0] cas_lat;
    logic burst_order_select_bit;
    logic [2:0] burst_len;
  } dmrb_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic first;
    logic last;
    logic [10:0] addr;
  } dmrb_col_t;

  typedef enum logic [1:0] {
    dmrb_st_idle,
    dmrb_st_read,
    dmrb_st_write
  } dmrb_state_t;

endpackage

// ===== logic/dmrb_burst_seq.sv
// In-block column offset for one beat of a burst
`timescale 1ns/1ns
`include "dmrb_params.svh"
module dmrb_burst_seq (
  input wire logic [2:0] start_off,
  input wire logic [2:0] beat,
  input wire logic [2:0] blk_mask,
  input wire logic order_sel,
  output logic [2:0] offset
);
  wire [2:0] seq_off;
  wire [2:0] il_off;

  assign seq_off = (start_off + beat) & blk_mask;
  assign il_off = (start_off ^ beat) & blk_mask;
  assign offset = order_sel ? il_off : seq_off;
endmodule

// ===== logic/dmrb_mode_burst.sv
// Mode register and burst column sequencer as seen inside the memory device
`timescale 1ns/1ns
`include "dmrb_params.svh"
module dmrb_mode_burst #(
  parameter bit WIDE_COL = 1'b0,
  parameter bit ROW_A12 = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dmrb_pkg::dmrb_cmd_t cmd,
  output dmrb_pkg::dmrb_mode_t mode_q,
  output logic mode_loaded_q,
  output logic mode_reserved_q,
  output logic dll_reset_q,
  output dmrb_pkg::dmrb_col_t col_q,
  output logic rd_launch_q,
  output logic rd_half_q,
  output logic load_conflict_q
);
  import dmrb_pkg::*;

  // Command decode
  wire sel;
  wire [2:0] op;
  wire is_lmr;
  wire is_mr_load;
  wire is_rd;
  wire is_wr;
  wire is_bst;
  wire [12:0] load_mask;
  dmrb_mode_t new_mode;

  assign sel = ~cmd.cs_n;
  assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign is_lmr = sel & (op == `DMRB_OP_LMR);
  assign is_mr_load = is_lmr & (cmd.ba == `DMRB_BA_MODE);
  assign is_rd = sel & (op == `DMRB_OP_READ);
  assign is_wr = sel & (op == `DMRB_OP_WRITE);
  assign is_bst = sel & (op == `DMRB_OP_BST);
  // Small densities have no A12 in the operating mode field
  assign load_mask = ROW_A12 ? 13'h1FFF : 13'h0FFF;
  assign new_mode = dmrb_mode_t'(cmd.addr & load_mask);

  // Decode of the stored mode
  wire len_bl2;
  wire len_bl4;
  wire len_bl8;
  wire len_ok;
  wire [2:0] cur_mask;
  wire cl_ok;
  wire opm_ok;
  wire [2:0] rd_tap;
  wire new_dll_rst;

  assign len_bl2 = (mode_q.burst_len == `DMRB_BL2);
  assign len_bl4 = (mode_q.burst_len == `DMRB_BL4);
  assign len_bl8 = (mode_q.burst_len == `DMRB_BL8);
  assign len_ok = len_bl2 | len_bl4 | len_bl8;
  assign cur_mask = len_bl8 ? `DMRB_MASK_BL8 : (len_bl4 ? `DMRB_MASK_BL4 : `DMRB_MASK_BL2);
  assign cl_ok = (mode_q.cas_lat == `DMRB_CL2) | (mode_q.cas_lat == `DMRB_CL25)
               | (mode_q.cas_lat == `DMRB_CL3);
  assign opm_ok = (mode_q.op_mode == `DMRB_OPM_NORMAL) | (mode_q.op_mode == `DMRB_OPM_DLL_RST);
  assign new_dll_rst = (new_mode.op_mode == `DMRB_OPM_DLL_RST);
  assign rd_tap = (mode_q.cas_lat == `DMRB_CL3) ? `DMRB_RD_TAP_CL3 :
                  (((mode_q.cas_lat == `DMRB_CL2) | (mode_q.cas_lat == `DMRB_CL25)) ?
                   `DMRB_RD_TAP_CL2 : `DMRB_RD_TAP_NONE);

  // Mode register
  dmrb_mode_t mode_d;
  logic loaded_d;

  assign loaded_d = mode_loaded_q | is_mr_load;

  always_comb begin
    mode_d = mode_q;
    if (is_mr_load) begin
      mode_d = new_mode;
    end else begin
      mode_d.op_mode[`DMRB_DLL_RST_BIT - `DMRB_OPM_LSB] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= dmrb_mode_t'(`DMRB_MR_RESET);
      mode_loaded_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      mode_loaded_q <= loaded_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dll_reset_q <= 1'b0;
      mode_reserved_q <= 1'b0;
    end else begin
      dll_reset_q <= is_mr_load & new_dll_rst;
      mode_reserved_q <= mode_loaded_q & ~(len_ok & cl_ok & opm_ok);
    end
  end

  // Column address from the command pins
  wire [10:0] col_in;
  wire rw_go;
  wire rd_go;

  // A11 joins the column only on the widest part
  assign col_in = {(WIDE_COL ? cmd.addr[`DMRB_COL_EXT_PIN] : 1'b0),
                   cmd.addr[`DMRB_COL_LO_W-1:0]};
  // one length for reads and writes
  assign rw_go = (is_rd | is_wr) & mode_loaded_q & len_ok;
  assign rd_go = is_rd & mode_loaded_q & len_ok;

  // Burst engine
  dmrb_state_t st_q;
  dmrb_state_t st_d;
  logic [2:0] beat_q;
  logic [2:0] beat_d;
  logic [2:0] start_q;
  logic [2:0] mask_q;
  logic [10:0] base_q;
  logic order_q;
  logic [2:0] offset;
  wire last_beat;
  wire active;

  assign active = (st_q != dmrb_st_idle);
  assign last_beat = (beat_q == mask_q);

  dmrb_burst_seq u_seq (
    .start_off(start_q),
    .beat(beat_q),
    .blk_mask(mask_q),
    .order_sel(order_q),
    .offset(offset)
  );

  always_comb begin
    st_d = st_q;
    beat_d = beat_q;
    case (st_q)
      dmrb_st_idle: begin
        beat_d = 3'h0;
      end
      dmrb_st_read, dmrb_st_write: begin
        beat_d = beat_q + 3'h1;
        if (last_beat) begin
          st_d = dmrb_st_idle;
        end
        // Terminate only cuts read bursts short
        if (is_bst && (st_q == dmrb_st_read)) begin
          st_d = dmrb_st_idle;
        end
      end
      default: begin
        st_d = dmrb_st_idle;
        beat_d = 3'h0;
      end
    endcase
    // A new read or write command truncates the running burst
    if (rw_go) begin
      st_d = is_wr ? dmrb_st_write : dmrb_st_read;
      beat_d = 3'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= dmrb_st_idle;
      beat_q <= 3'h0;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
    end
  end

  // Burst geometry latched at the command, so a late load cannot tear a burst
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 3'h0;
      mask_q <= 3'h0;
      base_q <= 11'h000;
      order_q <= 1'b0;
    end else if (rw_go) begin
      start_q <= col_in[2:0] & cur_mask;
      mask_q <= cur_mask;
      base_q <= col_in & ~{8'h00, cur_mask};
      order_q <= mode_q.burst_order_select_bit;
    end
  end

  // Column output, one location per clock
  dmrb_col_t col_d;

  always_comb begin
    col_d.valid = active & ~(is_bst & (st_q == dmrb_st_read));
    col_d.write = (st_q == dmrb_st_write);
    col_d.first = active & (beat_q == 3'h0);
    col_d.last = active & last_beat;
    col_d.addr = base_q | {8'h00, offset};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      col_q <= '0;
    end else begin
      col_q <= col_d;
    end
  end

  // Read launch pipeline; the half clock of 2.5 is reported, not timed
  logic [2:0] rd_sr_q;
  logic [2:0] rd_sr_d;

  assign rd_sr_d = {1'b0, rd_sr_q[2:1]} | (rd_go ? rd_tap : 3'h0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_sr_q <= 3'h0;
      rd_launch_q <= 1'b0;
      rd_half_q <= 1'b0;
    end else begin
      rd_sr_q <= rd_sr_d;
      rd_launch_q <= rd_sr_q[0];
      rd_half_q <= (mode_q.cas_lat == `DMRB_CL25);
    end
  end

  // Loading during a burst is outside the allowed use; flag it for the bench
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      load_conflict_q <= 1'b0;
    end else begin
      load_conflict_q <= is_lmr & active;
    end
  end

  // Helpers for the checks below
  logic [2:0] chk_beat_q;
  logic [2:0] chk_start_q;
  logic [2:0] chk_mask_q;
  logic chk_order_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chk_beat_q <= 3'h0;
      chk_start_q <= 3'h0;
      chk_mask_q <= 3'h0;
      chk_order_q <= 1'b0;
    end else begin
      chk_beat_q <= beat_q;
      chk_start_q <= start_q;
      chk_mask_q <= mask_q;
      chk_order_q <= order_q;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_load_stores: assert property (is_mr_load |=> mode_q[7:0] == $past(new_mode[7:0]))
    else $error("mode load did not store address bits");
  chk_ext_ignored: assert property ((is_lmr && cmd.ba != `DMRB_BA_MODE) |=> $stable(mode_q))
    else $error("extended load changed mode register");
  chk_a8_clears: assert property ((mode_q.op_mode[1] && !is_mr_load) |=> !mode_q.op_mode[1])
    else $error("DLL reset bit did not clear");
  chk_mode_retain: assert property (!is_mr_load |=> mode_q[7:0] == $past(mode_q[7:0]))
    else $error("mode bits changed without a load");
  chk_dll_pulse: assert property ((is_mr_load && new_dll_rst) |=> dll_reset_q ##1 !dll_reset_q)
    else $error("DLL reset pulse wrong");
  // Columns and read launch trail the command by one register stage after the state
  chk_first_col: assert property ((rw_go ##1 !is_bst) |=> col_q.valid && col_q.first
                                  && col_q.addr == $past(col_in, 2))
    else $error("first column is not the start column");
  chk_block_fixed: assert property ((col_q.valid && !col_q.first)
                   |-> (col_q.addr & ~{8'h00, chk_mask_q})
                       == ($past(col_q.addr) & ~{8'h00, chk_mask_q}))
    else $error("burst left its block");
  chk_seq_step: assert property ((col_q.valid && !col_q.first && !chk_order_q)
                |-> col_q.addr[2:0] == (($past(col_q.addr[2:0]) + 3'h1) & chk_mask_q
                    | ($past(col_q.addr[2:0]) & ~chk_mask_q)))
    else $error("sequential order broken");
  chk_il_order: assert property ((col_q.valid && chk_order_q)
                |-> ((col_q.addr[2:0] ^ chk_start_q) & chk_mask_q) == chk_beat_q)
    else $error("interleaved order broken");
  chk_len_eight: assert property ((rw_go && len_bl8) ##1 (!rw_go && !is_bst) [*8]
                 |=> col_q.valid && col_q.last ##1 !col_q.valid)
    else $error("length eight burst did not end on beat eight");
  chk_no_early: assert property (!mode_loaded_q |=> !col_q.valid)
    else $error("burst ran before mode load");
  chk_rd_cl3: assert property ((rd_go && mode_q.cas_lat == `DMRB_CL3) |=> ##3 rd_launch_q)
    else $error("read launch not three clocks after command");
  chk_rd_cl2: assert property ((rd_go && (mode_q.cas_lat == `DMRB_CL2
                               || mode_q.cas_lat == `DMRB_CL25)) |=> ##2 rd_launch_q)
    else $error("read launch not two clocks after command");
endmodule

// ===== testbench/dmrb_ctrl_model.sv
// Memory controller model that issues commands to the device
`timescale 1ns/1ns
`include "dmrb_params.svh"
module dmrb_ctrl_model #(
  parameter int MRD_GAP = 2
) (
  input wire logic clk_sys,
  output dmrb_pkg::dmrb_cmd_t cmd
);
  import dmrb_pkg::*;
  logic loaded;
  logic [12:0] mode;
  int hold;

  initial begin
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    loaded = 1'b0;
    mode = 13'h0000;
    hold = 0;
  end

  // One command edge, then deselect with scrambled lines so stale values never match
  task automatic issue(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] addr);
    repeat (hold) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd = '{1'b0, op[2], op[1], op[0], ba, addr};
    @(negedge clk_sys);
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~addr};
  endtask

  // callers pass only defined length, latency and mode encodings
  task automatic load(input logic [1:0] ba, input logic [12:0] word);
    issue(`DMRB_OP_LMR, ba, word);
    // bank bits low target the mode register
    if (ba == `DMRB_BA_MODE) begin
      mode = word;
      loaded = 1'b1;
    end
    // settle time before the next command
    hold = MRD_GAP;
  endtask

  task automatic burst(input logic wr, input logic [12:0] col);
    // bursts only after the mode register holds a value
    if (!loaded) begin
      $display("burst skipped, mode register never loaded");
    end else begin
      issue(wr ? `DMRB_OP_WRITE : `DMRB_OP_READ, 2'h0, col);
      // banks idle before a load: let the burst and its read data drain
      hold = (1 << mode[2:0]) + 3;
    end
  endtask

  // Terminate goes out on the next free edge, inside the running read
  task automatic stop();
    hold = 0;
    issue(`DMRB_OP_BST, 2'h0, 13'h0000);
    hold = (1 << mode[2:0]) + 3;
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the mode register and burst sequencer
`timescale 1ns/1ns
`include "dmrb_params.svh"
module tb;
  import dmrb_pkg::*;
  logic clk_sys;
  logic rst;
  dmrb_cmd_t cmd;
  dmrb_mode_t mode_q;
  dmrb_col_t col_q;
  logic mode_loaded_q;
  logic mode_reserved_q;
  logic dll_reset_q;
  logic rd_launch_q;
  logic rd_half_q;
  logic load_conflict_q;
  int fail_count;
  int num_checks;
  logic [12:0] word;

  dmrb_mode_burst #(.WIDE_COL(1'b0), .ROW_A12(1'b1)) dmrb_mode_burst_i (
    .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .mode_q(mode_q),
    .mode_loaded_q(mode_loaded_q), .mode_reserved_q(mode_reserved_q),
    .dll_reset_q(dll_reset_q), .col_q(col_q), .rd_launch_q(rd_launch_q),
    .rd_half_q(rd_half_q), .load_conflict_q(load_conflict_q));

  dmrb_ctrl_model #(.MRD_GAP(2)) dmrb_ctrl_model_i (.clk_sys(clk_sys), .cmd(cmd));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Expected columns come from the block base plus the ordered in-block offset
  task automatic run_burst(input logic wr, input logic bt, input logic [2:0] bl,
                           input logic [2:0] st, input int lat);
    logic [10:0] base;
    logic [2:0] msk;
    logic [2:0] off;
    int n;
    msk = (3'h1 << bl) - 3'h1;
    base = 11'h238 & ~{8'h00, msk};
    dmrb_ctrl_model_i.burst(wr, {2'h0, base | {8'h00, st & msk}});
    for (n = 0; n <= (1 << bl); n++) begin
      @(negedge clk_sys);
      off = bt ? ((st & msk) ^ n[2:0]) : (((st & msk) + n[2:0]) & msk);
      chk("read launch", {15'h0000, n == lat - 1 && !wr}, {15'h0000, rd_launch_q});
      chk("load conflict", 16'h0000, {15'h0000, load_conflict_q});
      if (n == (1 << bl)) chk("column valid", 16'h0000, {15'h0000, col_q.valid});
      else chk("column", {1'b1, wr, n == 0, n == (1 << bl) - 1, base | {8'h00, off}}, col_q);
    end
  endtask

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk("mode after reset", 16'h0000, mode_q);
    chk("loaded after reset", 16'h0000, {15'h0000, mode_loaded_q});
    dmrb_ctrl_model_i.load(2'h1, 13'h0032);
    @(negedge clk_sys);
    chk("mode after extended load", 16'h0000, mode_q);
    $display("test reset and extended load done");
    for (int bt = 0; bt < 2; bt++) begin
      for (int bl = 1; bl < 4; bl++) begin
        word = {6'h00, `DMRB_CL3, bt[0], bl[2:0]};
        dmrb_ctrl_model_i.load(2'h0, word);
        @(negedge clk_sys);
        chk("mode word", {3'h0, word}, mode_q);
        chk("length field", {13'h0000, bl[2:0]}, {13'h0000, mode_q.burst_len});
        chk("order field", {15'h0000, bt[0]}, {15'h0000, mode_q.burst_order_select_bit});
        chk("reserved flag", 16'h0000, {15'h0000, mode_reserved_q});
        chk("loaded flag", 16'h0001, {15'h0000, mode_loaded_q});
        chk("half latency flag", 16'h0000, {15'h0000, rd_half_q});
        run_burst(1'b0, bt[0], bl[2:0], 3'h5, 3);
        run_burst(1'b1, bt[0], bl[2:0], 3'h3, 3);
        run_burst(1'b0, bt[0], bl[2:0], 3'h6, 3);
        $display("test burst length code %0d order %0d done", bl, bt);
      end
    end
    dmrb_ctrl_model_i.burst(1'b0, 13'h0238);
    dmrb_ctrl_model_i.stop();
    chk("column after terminate", 16'h0000, {15'h0000, col_q.valid});
    @(negedge clk_sys);
    chk("column after burst end", 16'h0000, {15'h0000, col_q.valid});
    $display("test burst terminate done");
    word = {6'h00, `DMRB_CL2, 1'b0, `DMRB_BL4};
    dmrb_ctrl_model_i.load(2'h0, word);
    @(negedge clk_sys);
    chk("half latency flag", 16'h0000, {15'h0000, rd_half_q});
    run_burst(1'b0, 1'b0, `DMRB_BL4, 3'h1, 2);
    word = {6'h00, `DMRB_CL25, 1'b1, `DMRB_BL8};
    dmrb_ctrl_model_i.load(2'h0, word);
    @(negedge clk_sys);
    chk("half latency flag", 16'h0001, {15'h0000, rd_half_q});
    run_burst(1'b0, 1'b1, `DMRB_BL8, 3'h7, 2);
    $display("test short latencies done");
    // Pulse and the self-clearing bit stand for one cycle only, right after the load edge
    dmrb_ctrl_model_i.load(2'h0, 13'h0132);
    chk("delay loop reset pulse", 16'h0001, {15'h0000, dll_reset_q});
    chk("mode with delay loop bit", 16'h0132, mode_q);
    @(negedge clk_sys);
    chk("delay loop pulse end", 16'h0000, {15'h0000, dll_reset_q});
    chk("delay loop bit cleared", 16'h0032, mode_q);
    $display("test delay loop reset done");
    test_done();
  end

  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule
